// ==== inc/fifo_ctrl_pkg.sv ====
package fifo_ctrl_pkg;
    localparam int          DATA_W       = 8;
    localparam int          CNT_W        = 5;
    localparam logic [4:0]  QUEUE_DEPTH  = 5'h10;
    localparam logic [3:0]  PTR_RESET    = 4'h0;
    // Register word addresses (byte address = word index * 4)
    localparam logic [3:0]  ADDR_TX_CTRL = 4'h0;
    localparam logic [3:0]  ADDR_RX_CTRL = 4'h1;
    localparam logic [3:0]  ADDR_DATA    = 4'h2;
    localparam logic [3:0]  ADDR_STATUS  = 4'h3;
    localparam logic [3:0]  ADDR_MASK    = 4'h4;
    // Field positions, shared by both control registers except BIT_MODE_EN, which only the tx register has
    localparam int          BIT_MODE_EN  = 14;
    localparam int          BIT_Q_RST    = 13;
    localparam int          CNT_LSB      = 8;
    localparam int          BIT_FLAG     = 7;
    localparam int          BIT_CLR      = 6;
    localparam int          BIT_IEN      = 5;
    localparam logic [15:0] CTRL_RESET   = 16'h0000;
    localparam logic [4:0]  THRESH_RESET = 5'h00;
    localparam logic [1:0]  STATUS_RESET = 2'h0;
    localparam logic [1:0]  MASK_RESET   = 2'h0;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACK  = 2'b01
    } bus_state_t;
endpackage

// ==== inc/queue_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface queue_if;
    logic       push;
    logic       pop;
    logic       run;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [4:0] count;
    modport owner (output push, output pop, output run, output wdata,
                   input rdata, input count);
    modport store (input push, input pop, input run, input wdata,
                   output rdata, output count);
endinterface : queue_if
`default_nettype wire

// ==== rtl/byte_queue.sv ====
`timescale 1ns/10ps
`default_nettype none
module byte_queue (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic reset_n,
    // Queue port
    queue_if.store    q
);
    import fifo_ctrl_pkg::*;

    logic [7:0] mem [16];
    logic [3:0] wr_ptr_reg;
    logic [3:0] rd_ptr_reg;
    logic [4:0] count_reg;
    wire        do_push = q.run && q.push && (count_reg != QUEUE_DEPTH);
    wire        do_pop  = q.run && q.pop && (count_reg != 5'h00);

    assign q.rdata = mem[rd_ptr_reg];
    assign q.count = count_reg;

    always_ff @(posedge core_clk) begin
        if (do_push) begin
            mem[wr_ptr_reg] <= q.wdata;
        end
    end

    // Held at pointer zero while not running
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_reg <= PTR_RESET;
            rd_ptr_reg <= PTR_RESET;
            count_reg  <= 5'h00;
        end else if (!q.run) begin
            wr_ptr_reg <= PTR_RESET;
            rd_ptr_reg <= PTR_RESET;
            count_reg  <= 5'h00;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + 4'(do_push);
            rd_ptr_reg <= rd_ptr_reg + 4'(do_pop);
            count_reg  <= count_reg + 5'(do_push) - 5'(do_pop);
        end
    end
endmodule : byte_queue
`default_nettype wire

// ==== rtl/fifo_level_ctrl.sv ====
// Functional notes
// - Writing one to clear bit clears tx flag
// - Tx clear bit: zero ignored, reads zero
// - Tx request only when flag and enable
// - Tx flag sets when count at/below threshold
// - Rx reset bit zero holds rx queue empty
// - Rx reset bit one lets rx run
// - Rx count read in bits 12..8
// - Writing one to clear bit clears rx flag
// - Rx clear bit: zero ignored, reads zero
// - Rx request only when flag and enable
// - Rx flag sets when count at/above threshold
// - Rx bits 15..14 read zero
// - Queues run only with mode enable
// - Tx reset bit zero holds tx queue empty
// - Tx count read in bits 12..8
`timescale 1ns/10ps
`default_nettype none
module fifo_level_ctrl (
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 reset_n,
    // Avalon-MM slave
    input  wire logic [3:0]           avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    input  wire logic [3:0]           avs_byteenable,
    output logic      [31:0]          avs_readdata,
    output logic                      avs_waitrequest,
    // Shift logic side
    input  wire logic                 tx_take,
    output logic      [7:0]           tx_byte,
    output logic                      tx_byte_valid,
    input  wire logic                 rx_put,
    input  wire logic [7:0]           rx_byte,
    output logic                      rx_room,
    // Interrupts
    output logic                      tx_irq,
    output logic                      rx_irq,
    output logic                      irq
);
    import fifo_ctrl_pkg::*;

    queue_if txq ();
    queue_if rxq ();

    byte_queue u_txq (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .q        (txq.store)
    );
    byte_queue u_rxq (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .q        (rxq.store)
    );

    function automatic logic wr_lane(input logic [3:0] be, input int b);
        return be[b / 8];
    endfunction

    bus_state_t  bus_state_reg;
    logic        mode_en_reg;
    logic        tx_run_reg;
    logic        rx_run_reg;
    logic        tx_ien_reg;
    logic        rx_ien_reg;
    logic [4:0]  tx_thr_reg;
    logic [4:0]  rx_thr_reg;
    logic        tx_flag_reg;
    logic        rx_flag_reg;
    logic [1:0]  status_reg;
    logic [1:0]  mask_reg;
    logic [31:0] rdata_next;

    // Decode is registered one cycle: the request is answered in the ACK state
    wire acc      = (bus_state_reg == BUS_ACK);
    wire wr_fire  = acc && avs_write;
    wire rd_fire  = acc && avs_read;
    wire wr_tx    = wr_fire && (avs_address == ADDR_TX_CTRL);
    wire wr_rx    = wr_fire && (avs_address == ADDR_RX_CTRL);
    wire wr_data  = wr_fire && (avs_address == ADDR_DATA) && wr_lane(avs_byteenable, 0);
    wire wr_stat  = wr_fire && (avs_address == ADDR_STATUS) && wr_lane(avs_byteenable, 0);
    wire wr_mask  = wr_fire && (avs_address == ADDR_MASK) && wr_lane(avs_byteenable, 0);
    wire rd_data  = rd_fire && (avs_address == ADDR_DATA);
    wire lo_en    = wr_lane(avs_byteenable, 0);
    wire hi_en    = wr_lane(avs_byteenable, CNT_LSB);

    assign txq.run   = mode_en_reg && tx_run_reg;
    assign rxq.run   = mode_en_reg && rx_run_reg;
    assign txq.push  = wr_data;
    assign txq.wdata = avs_writedata[7:0];
    assign txq.pop   = tx_take;
    assign rxq.push  = rx_put;
    assign rxq.wdata = rx_byte;
    assign rxq.pop   = rd_data;

    wire tx_level  = txq.run && (txq.count <= tx_thr_reg);
    wire rx_level  = rxq.run && (rxq.count >= rx_thr_reg);
    wire tx_clr    = wr_tx && lo_en && avs_writedata[BIT_CLR];
    wire rx_clr    = wr_rx && lo_en && avs_writedata[BIT_CLR];
    wire tx_req    = tx_flag_reg && tx_ien_reg;
    wire rx_req    = rx_flag_reg && rx_ien_reg;
    wire [1:0] evt = {rx_level && !rx_flag_reg, tx_level && !tx_flag_reg};

    // Clear bit is never stored, so it always reads zero
    wire [15:0] tx_word = {1'b0, mode_en_reg, tx_run_reg, txq.count,
                           tx_flag_reg, 1'b0, tx_ien_reg, tx_thr_reg};
    wire [15:0] rx_word = {2'b00, rx_run_reg, rxq.count,
                           rx_flag_reg, 1'b0, rx_ien_reg, rx_thr_reg};

    always_comb begin
        rdata_next = 32'h0000_0000;
        unique case (avs_address)
            ADDR_TX_CTRL: rdata_next = {16'h0000, tx_word};
            ADDR_RX_CTRL: rdata_next = {16'h0000, rx_word};
            ADDR_DATA:    rdata_next = {24'h00_0000, rxq.rdata};
            ADDR_STATUS:  rdata_next = {30'h0000_0000, status_reg};
            ADDR_MASK:    rdata_next = {30'h0000_0000, mask_reg};
            default:      rdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_state_reg   <= BUS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            bus_state_reg   <= (!acc && (avs_read || avs_write)) ? BUS_ACK : BUS_IDLE;
            avs_waitrequest <= !(!acc && (avs_read || avs_write));
            avs_readdata    <= (!acc && avs_read) ? rdata_next : avs_readdata;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_en_reg <= CTRL_RESET[BIT_MODE_EN];
            tx_run_reg  <= CTRL_RESET[BIT_Q_RST];
            tx_ien_reg  <= CTRL_RESET[BIT_IEN];
            tx_thr_reg  <= THRESH_RESET;
        end else begin
            if (wr_tx && hi_en) begin
                mode_en_reg <= avs_writedata[BIT_MODE_EN];
                tx_run_reg  <= avs_writedata[BIT_Q_RST];
            end
            if (wr_tx && lo_en) begin
                tx_ien_reg <= avs_writedata[BIT_IEN];
                tx_thr_reg <= avs_writedata[4:0];
            end
        end
    end

    // Threshold and release may share one write, which avoids a spurious flag
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_run_reg <= CTRL_RESET[BIT_Q_RST];
            rx_ien_reg <= CTRL_RESET[BIT_IEN];
            rx_thr_reg <= THRESH_RESET;
        end else begin
            if (wr_rx && hi_en) begin
                rx_run_reg <= avs_writedata[BIT_Q_RST];
            end
            if (wr_rx && lo_en) begin
                rx_ien_reg <= avs_writedata[BIT_IEN];
                rx_thr_reg <= avs_writedata[4:0];
            end
        end
    end

    // Level condition wins over a clear in the same cycle
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_flag_reg <= 1'b0;
            rx_flag_reg <= 1'b0;
        end else begin
            tx_flag_reg <= tx_level || (tx_flag_reg && !tx_clr);
            rx_flag_reg <= rx_level || (rx_flag_reg && !rx_clr);
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            status_reg <= STATUS_RESET;
            mask_reg   <= MASK_RESET;
        end else begin
            status_reg <= evt | (status_reg & ~(wr_stat ? avs_writedata[1:0] : 2'b00));
            if (wr_mask) begin
                mask_reg <= avs_writedata[1:0];
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_irq        <= 1'b0;
            rx_irq        <= 1'b0;
            irq           <= 1'b0;
            tx_byte       <= 8'h00;
            tx_byte_valid <= 1'b0;
            rx_room       <= 1'b0;
        end else begin
            tx_irq        <= tx_req;
            rx_irq        <= rx_req;
            irq           <= |(status_reg & mask_reg);
            tx_byte       <= txq.rdata;
            tx_byte_valid <= txq.run && (txq.count != 5'h00) && !tx_take;
            rx_room       <= rxq.run && (rxq.count < QUEUE_DEPTH - 5'h01) && !rx_put;
        end
    end
endmodule : fifo_level_ctrl
`default_nettype wire

// ==== bench/level_ctrl_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
module level_ctrl_sva
    import fifo_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        reset_n,
    // Register bus
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // Shift side and interrupts
    input wire logic        tx_take,
    input wire logic [7:0]  tx_byte,
    input wire logic        tx_byte_valid,
    input wire logic        rx_put,
    input wire logic [7:0]  rx_byte,
    input wire logic        rx_room,
    input wire logic        tx_irq,
    input wire logic        rx_irq,
    input wire logic        irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    wire rd  = avs_read && !avs_waitrequest;
    wire wr0 = avs_write && !avs_waitrequest && avs_byteenable[0];
    wire wr1 = avs_write && !avs_waitrequest && avs_byteenable[1];
    a_req_answered: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("request not answered");
    a_ack_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("acknowledge longer than one cycle");
    a_clear_reads_zero: assert property (
        rd && avs_address <= ADDR_RX_CTRL |-> !avs_readdata[BIT_CLR]) else $error("clear bit read one");
    a_rx_reserved_zero: assert property (
        rd && avs_address == ADDR_RX_CTRL |-> avs_readdata[15:14] == 2'h0) else $error("reserved set");
    a_count_in_range: assert property (
        rd && avs_address <= ADDR_RX_CTRL |-> avs_readdata[12:8] <= QUEUE_DEPTH)
        else $error("count out of range");
    a_tx_irq_masked: assert property (
        wr0 && avs_address == ADDR_TX_CTRL && !avs_writedata[BIT_IEN] |-> ##2 !tx_irq)
        else $error("tx request while disabled");
    a_rx_irq_masked: assert property (
        wr0 && avs_address == ADDR_RX_CTRL && !avs_writedata[BIT_IEN] |-> ##2 !rx_irq)
        else $error("rx request while disabled");
    a_tx_hold_empty: assert property (
        wr1 && avs_address == ADDR_TX_CTRL && !avs_writedata[BIT_Q_RST] |-> ##2 !tx_byte_valid)
        else $error("tx queue not emptied");
    c_tx_irq: cover property (tx_irq);
    c_rx_irq: cover property (rx_irq);
    c_irq: cover property (irq);
    c_pop: cover property (rd && avs_address == ADDR_DATA);
endmodule // level_ctrl_sva
bind fifo_level_ctrl level_ctrl_sva u_sva (.*);
`default_nettype wire

// ==== bench/shift_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module shift_model (
    // Clock, reset and bench control
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    input  wire logic       tx_go,
    input  wire logic       rx_go,
    // Block side
    input  wire logic       tx_byte_valid,
    input  wire logic       rx_room,
    output logic            tx_take,
    output logic            rx_put,
    output logic [7:0]      rx_byte
);
    // Slow taker: head shows one cycle late, so never two takes in a row
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_take <= 1'b0;
            rx_put  <= 1'b0;
            rx_byte <= 8'h00;
        end else begin
            tx_take <= tx_go && tx_byte_valid && !tx_take;
            rx_put  <= rx_go && rx_room;
            rx_byte <= (rx_go && rx_room) ? rx_byte + 8'h01 : ~rx_byte;
        end
    end
endmodule // shift_model
`default_nettype wire

// ==== bench/i2c_fifo_level_irq_ctrl_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module i2c_fifo_level_irq_ctrl_tb_top import fifo_ctrl_pkg::*;;
    logic        core_clk = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'h3;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic        avs_waitrequest, tx_take, tx_byte_valid, rx_put, rx_room, tx_irq, rx_irq, irq;
    logic [7:0]  tx_byte, rx_byte;
    logic        tx_go = 1'b0, rx_go = 1'b0;
    int          error_cnt = 0, checked = 0, k, j;
    logic [7:0]  txd [16];
    logic [7:0]  d8;
    always #4 core_clk = ~core_clk;
    fifo_level_ctrl dut (.*);
    shift_model partner (.*);
    task automatic results;
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Holds the request until waitrequest is seen low; one idle edge after each access
    task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= {16'h0000, d};
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 40) begin
            error_cnt++;
            results();
        end
        @(posedge core_clk);
    endtask
    task automatic rd_chk(input string nm, input logic [3:0] a, input logic [15:0] e);
        bus(1'b0, a, 16'h0000);
        chk(nm, q, {16'h0000, e});
    endtask
    function automatic logic [15:0] rx_exp(input int n, input bit f);
        return 16'h2024 | 16'(n << 8) | (f ? 16'h0080 : 16'h0000);
    endfunction
    initial begin
        k = $urandom(79527);
        repeat (12) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        rd_chk("tx reset", ADDR_TX_CTRL, CTRL_RESET);
        rd_chk("rx reset", ADDR_RX_CTRL, CTRL_RESET);
        bus(1'b1, 4'hf, 16'hffff);
        rd_chk("unmapped", 4'hf, 16'h0000);
        bus(1'b1, ADDR_TX_CTRL, 16'h2000);
        bus(1'b1, ADDR_DATA, 16'h00a5);
        rd_chk("mode off", ADDR_TX_CTRL, 16'h2000);
        bus(1'b1, ADDR_TX_CTRL, 16'h6022);
        rd_chk("tx empty", ADDR_TX_CTRL, 16'h60a2);
        chk("tx irq", tx_irq, 1'b1);
        // One push past full must be dropped
        for (int i = 0; i < 17; i++) begin
            d8 = 8'($urandom_range(255));
            if (i < 16) txd[i] = d8;
            bus(1'b1, ADDR_DATA, {8'h00, d8});
        end
        rd_chk("tx full", ADDR_TX_CTRL, 16'h70a2);
        bus(1'b1, ADDR_TX_CTRL, 16'h6042);
        rd_chk("tx clear", ADDR_TX_CTRL, 16'h7002);
        // Valid drops between takes, so count the takes instead of watching valid
        tx_go <= 1'b1;
        j = 0;
        for (k = 0; k < 200 && j < 16; k++) begin
            @(posedge core_clk);
            if (tx_take === 1'b1) begin
                chk("tx byte", tx_byte, txd[j]);
                j++;
            end
        end
        tx_go <= 1'b0;
        if (j < 16) begin
            error_cnt++;
            results();
        end
        rd_chk("tx drained", ADDR_TX_CTRL, 16'h6082);
        chk("tx irq off", tx_irq, 1'b0);
        bus(1'b1, ADDR_TX_CTRL, 16'h4062);
        rd_chk("tx held", ADDR_TX_CTRL, 16'h40a2);
        bus(1'b1, ADDR_STATUS, 16'h0003);
        for (int it = 0; it < 4; it++) begin
            k = (it == 0) ? 4 : $urandom_range(1, 12);
            bus(1'b1, ADDR_RX_CTRL, 16'he064);
            // One byte per pulse; the gap lets the registered room flag recover
            for (int p = 0; p < k; p++) begin
                rx_go <= 1'b1;
                @(posedge core_clk);
                rx_go <= 1'b0;
                repeat (3) @(posedge core_clk);
            end
            repeat (3) @(posedge core_clk);
            rd_chk("rx level", ADDR_RX_CTRL, rx_exp(k, k >= 4));
            chk("rx irq", rx_irq, k >= 4);
            rd_chk("status", ADDR_STATUS, (k >= 4) ? 16'h0002 : 16'h0000);
            bus(1'b1, ADDR_MASK, 16'h0002);
            @(posedge core_clk);
            chk("irq on", irq, k >= 4);
            bus(1'b1, ADDR_STATUS, 16'h0002);
            @(posedge core_clk);
            chk("irq cleared", irq, 1'b0);
            bus(1'b0, ADDR_DATA, 16'h0000);
            rd_chk("rx pop", ADDR_RX_CTRL, rx_exp(k - 1, k >= 4));
            bus(1'b1, ADDR_RX_CTRL, 16'h0004);
            rd_chk("rx held", ADDR_RX_CTRL, (k >= 4) ? 16'h0084 : 16'h0004);
            bus(1'b1, ADDR_MASK, 16'h0000);
        end
        results();
    end
endmodule // i2c_fifo_level_irq_ctrl_tb_top
`default_nettype wire
